// ===== common/flash_fe_pkg.sv
// Shared constants, types and decode functions for the serial flash front end.
package flash_fe_pkg;

	// ------------------------------------------------------------
	// Framing and address layout
	// ------------------------------------------------------------
	localparam int OPCODE_BITS  = 8;
	localparam int ADDR_BITS    = 24;
	localparam int FRAME_BITS   = OPCODE_BITS + ADDR_BITS;
	localparam int PAGE_W       = 13;
	localparam int OFFS_W       = 10;
	localparam int STD_PAGE_LSB = 10;
	localparam int BIN_PAGE_LSB = 9;
	localparam int SECTORS      = 64;
	localparam int SECTOR_SHIFT = 7;
	localparam int CNT_W        = 6;
	localparam int TIMER_W      = 16;
	localparam int DCNT_W       = 7;

	// ------------------------------------------------------------
	// Opcodes (arbitrary values)
	// ------------------------------------------------------------
	localparam logic [7:0] OP_PAGE_PROG     = 8'h10;
	localparam logic [7:0] OP_BYTE_PROG     = 8'h11;
	localparam logic [7:0] OP_ERASE_PAGE    = 8'h20;
	localparam logic [7:0] OP_ERASE_BLOCK   = 8'h21;
	localparam logic [7:0] OP_ERASE_SECTOR  = 8'h22;
	localparam logic [7:0] OP_ERASE_CHIP    = 8'h23;
	localparam logic [7:0] OP_PROT_ENABLE   = 8'h30;
	localparam logic [7:0] OP_SECTOR_FREEZE = 8'h31;
	localparam logic [7:0] OP_MAP_WRITE     = 8'h32;
	localparam logic [7:0] OP_STATUS_READ   = 8'h40;

	// ------------------------------------------------------------
	// Status byte bit positions
	// ------------------------------------------------------------
	localparam int ST_BIT_BUSY = 7;
	localparam int ST_BIT_WP   = 6;
	localparam int ST_BIT_SWEN = 5;
	localparam int ST_BIT_BIN  = 4;
	localparam int ST_BIT_SEEN = 3;

	typedef enum logic [3:0] {
		K_NONE, K_PAGE_PROG, K_BYTE_PROG, K_ERASE_PAGE, K_ERASE_BLOCK,
		K_ERASE_SECTOR, K_ERASE_CHIP, K_PROT_ENABLE, K_SECTOR_FREEZE,
		K_MAP_WRITE, K_STATUS
	} cmd_kind_e;

	typedef struct packed {
		logic              valid;
		cmd_kind_e         kind;
		logic [PAGE_W-1:0] page_number_bits;
		logic [OFFS_W-1:0] byte_in_page_bits;
		logic [OFFS_W-1:0] buffer_offset;
	} flash_cmd_s;

	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
		logic wp_n;
		logic reset_n;
	} spi_pins_s;

	localparam spi_pins_s PINS_IDLE = '{cs_n: 1'h1, sck: 1'h0, si: 1'h0, wp_n: 1'h1,
		reset_n: 1'h1};

	// ------------------------------------------------------------
	// Decode functions
	// ------------------------------------------------------------
	function automatic cmd_kind_e opcode_kind(input logic [7:0] op);
		cmd_kind_e k;
		k = K_NONE;
		if (op == OP_PAGE_PROG) k = K_PAGE_PROG;
		else if (op == OP_BYTE_PROG) k = K_BYTE_PROG;
		else if (op == OP_ERASE_PAGE) k = K_ERASE_PAGE;
		else if (op == OP_ERASE_BLOCK) k = K_ERASE_BLOCK;
		else if (op == OP_ERASE_SECTOR) k = K_ERASE_SECTOR;
		else if (op == OP_ERASE_CHIP) k = K_ERASE_CHIP;
		else if (op == OP_PROT_ENABLE) k = K_PROT_ENABLE;
		else if (op == OP_SECTOR_FREEZE) k = K_SECTOR_FREEZE;
		else if (op == OP_MAP_WRITE) k = K_MAP_WRITE;
		else if (op == OP_STATUS_READ) k = K_STATUS;
		return k;
	endfunction

	function automatic logic is_prog_erase(input cmd_kind_e k);
		return (k == K_PAGE_PROG) || (k == K_BYTE_PROG) || (k == K_ERASE_PAGE) ||
			(k == K_ERASE_BLOCK) || (k == K_ERASE_SECTOR) || (k == K_ERASE_CHIP);
	endfunction

	// Real address bits sit right-justified; leading dummy bits are dropped.
	function automatic flash_cmd_s decode_addr(input logic [ADDR_BITS-1:0] a,
		input logic bin, input cmd_kind_e k);
		flash_cmd_s c;
		c = '0;
		c.kind = k;
		if (bin) begin
			c.page_number_bits  = a[BIN_PAGE_LSB +: PAGE_W];
			c.byte_in_page_bits = {1'h0, a[BIN_PAGE_LSB-1:0]};
		end else begin
			c.page_number_bits  = a[STD_PAGE_LSB +: PAGE_W];
			c.byte_in_page_bits = a[STD_PAGE_LSB-1:0];
		end
		c.buffer_offset = c.byte_in_page_bits;
		return c;
	endfunction

endpackage

// ===== logic/pin_sync.sv
// Two-stage synchroniser for the serial flash pins.
`timescale 1ns/1ps
module pin_sync
	import flash_fe_pkg::*;
(
	input  wire logic      i_clock,
	input  wire logic      i_rst,
	input  wire logic      i_ce,
	input  wire spi_pins_s i_pins,
	output spi_pins_s      o_pins
);

	typedef struct packed {
		spi_pins_s meta;
		spi_pins_s sync;
	} sync_s;

	sync_s s;
	sync_s next_s;

	// The first stage feeds only the second one.
	always_comb begin
		next_s      = s;
		next_s.meta = i_pins;
		next_s.sync = s.meta;
	end

	// Idle pin levels at reset hold write-protect deasserted until the sampled pins have passed through both stages.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			s <= '{meta: PINS_IDLE, sync: PINS_IDLE};
		end else if (i_ce) begin
			s <= next_s;
		end
	end

	assign o_pins = s.sync;

endmodule

// ===== logic/serial_flash_front_end.sv
// Serial flash front end: framing, protection, reset and address decode.
`timescale 1ns/1ps
// ------------------------------------------------------------
// Behaviour
// - Serial output changes on clock falling edges
// - Output tri-stated while chip deselected
// - Write-protect blocks protected sectors always
// - Protect map frozen after write-protect low
// - Program/erase under write-protect does nothing
// - Enable and freeze work under write-protect
// - Floating write-protect counts as deasserted (code: wp_n reads high only while in reset, nothing pulls it up after)
// - Reset pin aborts, control returns idle
// - Held in reset while pin low
// - Power-on reset needs no pin sequencing
// - All fields shift most significant first
// - Three address bytes with dummy bits
// - Standard pages: 13 page, 10 offset
// - Binary pages: 13 page, 9 offset
// - Page/byte program, four erase granularities
// - Input sampled on rising edges only
// - Self-timed cycle completes before standby
// ------------------------------------------------------------
module serial_flash_front_end
	import flash_fe_pkg::*;
#(
	parameter logic [TIMER_W-1:0] PROG_CYCLES = 16'h03E8
) (
	input  wire logic      i_clock,
	input  wire logic      i_rst,
	input  wire logic      i_ce,
	input  wire spi_pins_s i_pins,
	input  wire logic      i_binary_page,
	output logic           o_so,
	output logic           o_so_oe,
	output flash_cmd_s     o_cmd,
	output logic           o_blocked,
	output logic           o_busy,
	output logic           o_sw_protect
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [2:0] {ST_IDLE, ST_SHIFT, ST_DATA, ST_IGNORE, ST_BUSY} fe_state_e;

	typedef struct packed {
		fe_state_e            st;
		logic [CNT_W-1:0]     cnt;
		logic [FRAME_BITS-1:0] sr;
		logic [7:0]           out_sr;
		logic [SECTORS-1:0]   shadow;
		logic [DCNT_W-1:0]    data_cnt;
		logic [SECTORS-1:0]   map;
		logic [SECTORS-1:0]   frozen;
		logic                 sw_en;
		logic                 wp_seen;
		logic                 prev_sck;
		logic                 prev_cs;
		cmd_kind_e            kind;
		logic [TIMER_W-1:0]   timer;
		logic                 so;
		logic                 so_oe;
		logic                 blocked;
		logic                 busy;
		flash_cmd_s           cmd;
	} fe_s;

	fe_s       s;
	fe_s       next_s;
	spi_pins_s pins;
	logic      rise;
	logic      fall;
	logic      cs_fall;
	logic      cs_rise;
	flash_cmd_s dec;
	logic [PAGE_W-SECTOR_SHIFT-1:0] sec;
	logic      prot;
	logic [7:0] op_now;

	pin_sync u_sync (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_ce    (i_ce),
		.i_pins  (i_pins),
		.o_pins  (pins)
	);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.cmd.valid = 1'h0;
		next_s.blocked = 1'h0;
		next_s.prev_sck = pins.sck;
		next_s.prev_cs = pins.cs_n;
		rise = pins.sck && !s.prev_sck;
		fall = !pins.sck && s.prev_sck;
		cs_fall = !pins.cs_n && s.prev_cs;
		cs_rise = pins.cs_n && !s.prev_cs;
		op_now = {s.sr[OPCODE_BITS-2:0], pins.si};
		dec = decode_addr(s.sr[ADDR_BITS-1:0], i_binary_page, s.kind);
		sec = dec.page_number_bits[PAGE_W-1:SECTOR_SHIFT];
		if (s.kind == K_ERASE_CHIP) begin
			prot = (|s.frozen) || (s.sw_en && (|s.map));
		end else begin
			prot = s.frozen[sec] || (s.sw_en && s.map[sec]);
		end
		next_s.so_oe = !pins.cs_n;
		if (!pins.wp_n) begin
			next_s.wp_seen = 1'h1;
		end
		case (s.st)
			ST_IDLE: begin
				if (cs_fall) begin
					next_s.st = ST_SHIFT;
					next_s.cnt = '0;
					next_s.data_cnt = '0;
				end
			end
			ST_SHIFT: begin
				if (cs_rise) begin
					next_s.st = ST_IDLE;
				end else if (rise) begin
					next_s.sr = {s.sr[FRAME_BITS-2:0], pins.si};
					next_s.cnt = s.cnt + 1'h1;
					if (s.cnt == CNT_W'(OPCODE_BITS - 1)) begin
						next_s.kind = opcode_kind(op_now);
						if (next_s.kind == K_NONE) begin
							next_s.st = ST_IGNORE;
						end else if (next_s.kind == K_STATUS) begin
							next_s.out_sr = '0;
							next_s.out_sr[ST_BIT_BUSY] = s.busy;
							next_s.out_sr[ST_BIT_WP] = !pins.wp_n;
							next_s.out_sr[ST_BIT_SWEN] = s.sw_en;
							next_s.out_sr[ST_BIT_BIN] = i_binary_page;
							next_s.out_sr[ST_BIT_SEEN] = s.wp_seen;
							next_s.st = ST_DATA;
						end else if (next_s.kind == K_PROT_ENABLE) begin
							next_s.st = ST_DATA;
						end
					end else if (s.cnt == CNT_W'(FRAME_BITS - 1)) begin
						next_s.st = ST_DATA;
					end
				end
			end
			ST_DATA: begin
				if (cs_rise) begin
					next_s.st = ST_IDLE;
					if (is_prog_erase(s.kind)) begin
						if (!pins.wp_n || prot) begin
							next_s.blocked = 1'h1;
						end else begin
							next_s.cmd = dec;
							next_s.cmd.valid = 1'h1;
							next_s.st = ST_BUSY;
							next_s.timer = '0;
						end
					end else if (s.kind == K_PROT_ENABLE) begin
						next_s.sw_en = 1'h1;
					end else if (s.kind == K_SECTOR_FREEZE) begin
						next_s.frozen[sec] = 1'h1;
					end else if (s.kind == K_MAP_WRITE) begin
						if (!next_s.wp_seen && s.data_cnt >= DCNT_W'(SECTORS)) begin
							next_s.map = s.shadow;
						end
					end
				end else begin
					if (rise) begin
						next_s.shadow = {s.shadow[SECTORS-2:0], pins.si};
						if (s.data_cnt != '1) begin
							next_s.data_cnt = s.data_cnt + 1'h1;
						end
					end
					// Mode 0 and mode 3 both see a stable bit across the next rise.
					if (fall) begin
						next_s.so = s.out_sr[7];
						next_s.out_sr = {s.out_sr[6:0], s.out_sr[7]};
					end
				end
			end
			ST_IGNORE: begin
				if (cs_rise) begin
					next_s.st = ST_IDLE;
				end
			end
			ST_BUSY: begin
				// Frames during the internal cycle are not seen; standby waits for it.
				next_s.timer = s.timer + 1'h1;
				if (s.timer == PROG_CYCLES - 1'h1) begin
					next_s.st = ST_IDLE;
				end
			end
			default: next_s.st = ST_IDLE;
		endcase
		// Protection state survives a pin reset; only the control path is aborted.
		if (!pins.reset_n) begin
			next_s.st = ST_IDLE;
			next_s.cnt = '0;
			next_s.timer = '0;
			next_s.kind = K_NONE;
			next_s.blocked = 1'h0;
			next_s.cmd.valid = 1'h0;
		end
		next_s.busy = (next_s.st == ST_BUSY);
	end

	always_ff @(posedge i_clock) begin
		// Chip select is remembered as deselected so reset shows no false edge.
		if (i_rst) begin
			s         <= '0;
			s.prev_cs <= 1'h1;
		end else if (i_ce) begin
			s <= next_s;
		end
	end

	assign o_so         = s.so;
	assign o_so_oe      = s.so_oe;
	assign o_cmd        = s.cmd;
	assign o_blocked    = s.blocked;
	assign o_busy       = s.busy;
	assign o_sw_protect = s.sw_en;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_so_on_fall: assert property (@(posedge i_clock) disable iff (i_rst || !i_ce)
		$changed(o_so) |-> $past(fall))
		else $error("Serial output changed without a clock falling edge.");

	a_deselect_hiz: assert property (@(posedge i_clock) disable iff (i_rst || !i_ce)
		pins.cs_n |=> !o_so_oe)
		else $error("Serial output driven while deselected.");

	a_wp_blocks_op: assert property (@(posedge i_clock) disable iff (i_rst || !i_ce)
		(s.st == ST_DATA && cs_rise && is_prog_erase(s.kind) && !pins.wp_n && pins.reset_n)
		|=> (o_blocked && !o_cmd.valid))
		else $error("Program or erase accepted under write-protect.");

	a_map_locked: assert property (@(posedge i_clock) disable iff (i_rst || !i_ce)
		s.wp_seen |=> $stable(s.map))
		else $error("Protect map changed after write-protect went low.");

	a_block_to_idle: assert property (@(posedge i_clock) disable iff (i_rst || !i_ce)
		o_blocked |-> (s.st == ST_IDLE && !o_busy))
		else $error("Blocked command did not return to idle.");

	a_enable_under_wp: assert property (@(posedge i_clock) disable iff (i_rst || !i_ce)
		(s.st == ST_DATA && cs_rise && s.kind == K_PROT_ENABLE && pins.reset_n)
		|=> o_sw_protect)
		else $error("Protection enable not taken.");

	a_reset_pin_idle: assert property (@(posedge i_clock) disable iff (i_rst || !i_ce)
		!pins.reset_n |=> (s.st == ST_IDLE && !o_busy && !o_cmd.valid))
		else $error("Reset pin did not return control to idle.");

	a_busy_after_cmd: assert property (@(posedge i_clock) disable iff (i_rst || !i_ce)
		(o_cmd.valid && pins.reset_n) |-> o_busy ##1 o_busy)
		else $error("Accepted command did not start its internal cycle.");

	a_bin_decode: assert property (@(posedge i_clock) disable iff (i_rst || !i_ce)
		(o_cmd.valid && i_binary_page) |-> (o_cmd.byte_in_page_bits[OFFS_W-1] == 1'h0))
		else $error("Binary page offset wider than nine bits.");

endmodule

// ===== verif/spi_host_model.sv
// Behavioural host controller that frames instructions on the serial pins.
`timescale 1ns/1ps
module spi_host_model (
	input  wire logic i_clock,
	input  wire logic i_so,
	output logic      o_cs_n,
	output logic      o_sck,
	output logic      o_si
);
	logic [7:0] rx;

	initial begin
		o_cs_n = 1'h1;
		o_sck  = 1'h0;
		o_si   = 1'h0;
		rx     = 8'h00;
	end

	// ------------------------------------------------------------
	// Frame driver
	// ------------------------------------------------------------
	// Half a serial clock is five system clocks, so the link runs at 80 ns.
	task automatic half();
		repeat (5) @(negedge i_clock);
	endtask

	// Shifts the low n bits of d inside one select; the serial clock idles low.
	task automatic frame(input logic [103:0] d, input int n);
		o_cs_n = 1'h0;
		half();
		for (int i = n - 1; i >= 0; i--) begin
			o_si = d[i];
			half();
			o_sck = 1'h1;
			rx    = {rx[6:0], i_so};
			half();
			o_sck = 1'h0;
		end
		half();
		o_cs_n = 1'h1;
		o_si   = ~o_si;
		half();
	endtask
endmodule

// ===== verif/serial_flash_front_end_tb.sv
// Self-checking bench for the serial flash front end.
`timescale 1ns/1ps
module serial_flash_front_end_tb;
	import flash_fe_pkg::*;
	logic       i_clock = 1'h0;
	logic       i_rst   = 1'h1;
	logic       wp_n    = 1'h1;
	logic       reset_n = 1'h1;
	logic       bin     = 1'h0;
	logic       cs_n, sck, si, so, so_oe, blocked, busy, sw_prot;
	flash_cmd_s cmd, last;
	spi_pins_s  pins;
	int         miscompares = 0;
	int         n_checks = 0;
	int         n_valid, n_block, busy_len;

	always #4 i_clock = ~i_clock;
	assign pins = '{cs_n: cs_n, sck: sck, si: si, wp_n: wp_n, reset_n: reset_n};

	spi_host_model host (.i_clock(i_clock), .i_so(so_oe ? so : 1'hZ), .o_cs_n(cs_n),
		.o_sck(sck), .o_si(si));
	serial_flash_front_end #(.PROG_CYCLES(16'h0008)) dut (.i_clock(i_clock), .i_rst(i_rst),
		.i_ce(1'h1), .i_pins(pins), .i_binary_page(bin), .o_so(so), .o_so_oe(so_oe),
		.o_cmd(cmd), .o_blocked(blocked), .o_busy(busy), .o_sw_protect(sw_prot));

	always @(posedge i_clock) begin
		if (cmd.valid === 1'h1) begin
			n_valid++;
			last = cmd;
		end
		if (blocked === 1'h1) n_block++;
		if (busy === 1'h1) busy_len++;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask

	// Thirty idle cycles cover the answer latency and the shortened busy span.
	task automatic run(input logic [103:0] d, input int n);
		n_valid  = 0;
		n_block  = 0;
		busy_len = 0;
		host.frame(d, n);
		repeat (30) @(negedge i_clock);
	endtask

	task automatic op(input logic [7:0] o, input logic [23:0] a);
		run({72'h0, o, a}, 32);
	endtask

	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		check(32'(so_oe), 32'h0);
		check(32'({busy, sw_prot, cmd.valid}), 32'h0);
		$display("test reset done");
	endtask

	// Every program and erase code in standard pages; the top dummy bit is set.
	task automatic t_std();
		logic [7:0] ops[6] = '{OP_PAGE_PROG, OP_BYTE_PROG, OP_ERASE_PAGE, OP_ERASE_BLOCK,
			OP_ERASE_SECTOR, OP_ERASE_CHIP};
		cmd_kind_e  ks[6] = '{K_PAGE_PROG, K_BYTE_PROG, K_ERASE_PAGE, K_ERASE_BLOCK,
			K_ERASE_SECTOR, K_ERASE_CHIP};
		logic [23:0] a;
		for (int i = 0; i < 6; i++) begin
			a = 24'hD5A3C6 ^ 24'(i);
			op(ops[i], a);
			check(32'(n_valid), 32'h1);
			check(32'(last.kind), 32'(ks[i]));
			check(32'(last.page_number_bits), 32'(a[22:10]));
			check(32'(last.byte_in_page_bits), 32'(a[9:0]));
			check(32'(last.buffer_offset), 32'(a[9:0]));
			check(32'(busy_len), 32'h8);
		end
		op(8'hFF, 24'h060000);
		check(32'(n_valid), 32'h0);
		check(32'(n_block), 32'h0);
		run({88'h0, OP_PAGE_PROG, 8'h06}, 16);
		check(32'(n_valid), 32'h0);
		check(32'(busy_len), 32'h0);
		$display("test standard pages done");
	endtask

	task automatic t_bin();
		bin = 1'h1;
		op(OP_ERASE_PAGE, 24'hE9B5A7);
		check(32'(last.page_number_bits), 32'h14DA);
		check(32'(last.byte_in_page_bits), 32'h01A7);
		run({88'h0, OP_STATUS_READ, 8'h00}, 16);
		check(32'(host.rx), 32'h10);
		check(32'(so_oe), 32'h0);
		bin = 1'h0;
		$display("test binary pages done");
	endtask

	// Sector 2 is mapped before write-protect, then the map is frozen by it.
	task automatic t_protect();
		run({OP_MAP_WRITE, 24'h0, 64'h4, 8'h0} >> 8, 96);
		wp_n = 1'h0;
		op(OP_PAGE_PROG, 24'h0A0000);
		check(32'(n_block), 32'h1);
		check(32'(n_valid), 32'h0);
		check(32'(busy_len), 32'h0);
		run({OP_MAP_WRITE, 24'h0, 64'h0, 8'h0} >> 8, 96);
		run({96'h0, OP_PROT_ENABLE}, 8);
		check(32'(sw_prot), 32'h1);
		op(OP_SECTOR_FREEZE, 24'h080000);
		wp_n = 1'h1;
		op(OP_PAGE_PROG, 24'h040000);
		check(32'(n_block), 32'h1);
		check(32'(n_valid), 32'h0);
		op(OP_PAGE_PROG, 24'h080000);
		check(32'(n_block), 32'h1);
		check(32'(n_valid), 32'h0);
		op(OP_PAGE_PROG, 24'h060000);
		check(32'(n_block), 32'h0);
		check(32'(n_valid), 32'h1);
		$display("test protection done");
	endtask

	// Reset pin low mid-frame drops it; low while busy ends the cycle early.
	task automatic t_pin_reset();
		fork
			op(OP_ERASE_BLOCK, 24'h0C0000);
			begin
				repeat (100) @(negedge i_clock);
				reset_n = 1'h0;
				repeat (10) @(negedge i_clock);
				reset_n = 1'h1;
			end
		join
		check(32'(n_valid), 32'h0);
		check(32'(n_block), 32'h0);
		fork
			op(OP_ERASE_BLOCK, 24'h0C0000);
			begin
				wait (cs_n === 1'h0);
				for (int i = 0; i < 1000 && busy !== 1'h1; i++) @(negedge i_clock);
				reset_n = 1'h0;
				repeat (5) @(negedge i_clock);
				check(32'(busy), 32'h0);
				reset_n = 1'h1;
			end
		join
		op(OP_ERASE_BLOCK, 24'h0C0000);
		check(32'(n_valid), 32'h1);
		$display("test reset pin done");
	endtask

	initial begin
		repeat (6) @(negedge i_clock);
		i_rst = 1'h0;
		repeat (5) @(negedge i_clock);
		t_reset();
		t_std();
		t_bin();
		t_protect();
		t_pin_reset();
		end_sim();
	end

	initial begin
		#500000;
		miscompares++;
		end_sim();
	end
endmodule
